// >>> rtl/cmf_pkg.sv
// constants for the configurable message framer
package cmf_pkg;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_FRAME  = 8'h04;
    localparam logic [7:0] REG_ADDR   = 8'h08;
    localparam logic [7:0] REG_DATA   = 8'h0c;
    localparam logic [7:0] REG_BASE   = 8'h10;
    localparam logic [7:0] REG_STEP   = 8'h14;
    localparam logic [7:0] REG_MTX    = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [1:0] CMD_SEND   = 2'h0;
    localparam logic [1:0] CMD_RECV   = 2'h1;
    localparam logic [1:0] CMD_SR     = 2'h2;
    localparam logic [1:0] CHK_SUM    = 2'h0;
    localparam logic [1:0] CHK_LRC    = 2'h1;
    localparam logic [1:0] CHK_CRC    = 2'h2;
    localparam logic [7:0] CRC_POLY   = 8'h07;
    localparam logic [1:0] CONV_NONE  = 2'h0;
    localparam logic [1:0] CONV_ASCII = 2'h1;
    localparam logic [1:0] CONV_HEX   = 2'h2;
    localparam logic [1:0] ATTR_CONST = 2'h0;
    localparam logic [1:0] ATTR_READ  = 2'h1;
    localparam logic [1:0] ATTR_WILD  = 2'h2;
    localparam logic [1:0] ATTR_WRITE = 2'h3;
    localparam logic [1:0] REF_OPND   = 2'h0;
    localparam logic [1:0] REF_LRECV  = 2'h1;
    localparam logic [1:0] REF_LSEND  = 2'h2;
    localparam logic [1:0] REF_ABS    = 2'h3;
    localparam logic [1:0] ACT_END    = 2'h0;
    localparam logic [1:0] ACT_GOTO   = 2'h1;
    localparam logic [1:0] ACT_NEXT   = 2'h2;
    localparam logic [1:0] ACT_ABORT  = 2'h3;
    localparam int MTX_TYPES = 15;
    localparam int MEM_WIN_BIT = 10;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000, ST_THDR = 4'b0001, ST_TADR = 4'b0010, ST_TLEN = 4'b0011,
        ST_TDAT = 4'b0100, ST_TCHK = 4'b0101, ST_TEND = 4'b0110, ST_RHDR = 4'b0111,
        ST_RADR = 4'b1000, ST_RLEN = 4'b1001, ST_RDAT = 4'b1010, ST_RCHK = 4'b1011,
        ST_REND = 4'b1100, ST_FIN  = 4'b1101
    } cmf_state_t;
endpackage : cmf_pkg

// >>> rtl/cmf_framer.sv
// message framer: builds, checks and files framed serial messages
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module cmf_framer
    import cmf_pkg::*;
#(
    parameter int MEM_WORDS = 256
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [10:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [7:0]  txData,
    output logic             txValid,
    input  wire logic        txReady,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxValid,
    output logic             busy
);
    if (MEM_WORDS != 256) begin : g_chk
        $error("cmf_framer: MEM_WORDS must be 256");
    end

    logic [7:0]  mem [MEM_WORDS];
    logic [31:0] ctrl_q, ctrl_d, frame_q, frame_d, addr_q, addr_d;
    logic [31:0] data_q, data_d, base_q, base_d, step_q, step_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wait_q, wait_d, go_q, go_d;
    logic [8:0]  mtx_q [MTX_TYPES];
    logic [8:0]  mtx_d [MTX_TYPES];

    cmf_state_t  st_q, st_d;
    logic [7:0]  n_q, n_d, idx_q, idx_d, len_q, len_d, chk_q, chk_d;
    logic [7:0]  rxAdr_q, rxAdr_d, txData_q, txData_d;
    logic        txValid_q, txValid_d;
    logic        done_q, done_d, err_q, err_d, abort_q, abort_d, bad_q, bad_d;
    logic [3:0]  mtype_q, mtype_d;
    logic        memWe;
    logic [7:0]  memWa, memWd;

    // field decode
    wire logic [1:0] cmd   = ctrl_q[2:1];
    wire logic [1:0] chkT  = ctrl_q[4:3];
    wire logic [1:0] conv  = ctrl_q[6:5];
    wire logic [1:0] aAttr = addr_q[9:8];
    wire logic [1:0] dAttr = data_q[1:0];
    wire logic [7:0] dCnt  = data_q[11:4];
    wire logic [7:0] rep   = step_q[7:0];
    wire logic       split = conv != CONV_NONE;
    wire logic       regWr = avs_write && !wait_q;
    wire logic       isMem = avs_address[MEM_WIN_BIT];
    wire logic [7:0] wIdx  = avs_address[9:2];

    function automatic logic [7:0] refBase(input logic [1:0] m);
        case (m)
            REF_OPND:  refBase = base_q[7:0];
            REF_LRECV: refBase = base_q[15:8];
            REF_LSEND: refBase = base_q[23:16];
            default:   refBase = 8'h00;
        endcase
    endfunction : refBase

    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        crcStep = r;
    endfunction : crcStep

    function automatic logic [7:0] chkNext(input logic [7:0] c, input logic [7:0] b);
        case (chkT)
            CHK_SUM: chkNext = c + b;
            CHK_LRC: chkNext = c ^ b;
            default: chkNext = crcStep(c, b);
        endcase
    endfunction : chkNext

    function automatic logic [7:0] hexChar(input logic [3:0] v);
        hexChar = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
    endfunction : hexChar

    // scale times index plus offset, kept to the memory width
    logic [15:0] prod;
    logic [7:0]  dRef, aRef, dWord, sendByte;
    logic [3:0]  nib;
    always_comb begin
        prod = data_q[27:20] * n_q;
        dRef = refBase(data_q[3:2]) + data_q[19:12] + prod[7:0];
        aRef = refBase(addr_q[11:10]) + addr_q[19:12] + prod[7:0];
        dWord = mem[dRef + (split ? {1'b0, idx_q[7:1]} : idx_q)];
        nib = idx_q[0] ? dWord[3:0] : dWord[7:4];
        case (conv)
            CONV_ASCII: sendByte = hexChar(nib);
            CONV_HEX:   sendByte = {4'h0, nib};
            default:    sendByte = dWord;
        endcase
    end

    // bus slave: one cycle of wait (memory writes also wait while busy), then a one-cycle answer
    always_comb begin
        ctrl_d = ctrl_q;
        frame_d = frame_q;
        addr_d = addr_q;
        data_d = data_q;
        base_d = base_q;
        step_d = step_q;
        mtx_d = mtx_q;
        go_d = 1'b0;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        if ((avs_read || avs_write) && wait_q && !(isMem && avs_write && busy)) begin
            wait_d = 1'b0;
            if (isMem) begin
                rdata_d = {24'h0, mem[wIdx]};
            end else if (avs_address[7:0] == REG_CTRL) begin
                rdata_d = {25'h0, ctrl_q[6:1], 1'b0};
            end else if (avs_address[7:0] == REG_FRAME) begin
                rdata_d = frame_q;
            end else if (avs_address[7:0] == REG_ADDR) begin
                rdata_d = addr_q;
            end else if (avs_address[7:0] == REG_DATA) begin
                rdata_d = data_q;
            end else if (avs_address[7:0] == REG_BASE) begin
                rdata_d = base_q;
            end else if (avs_address[7:0] == REG_STEP) begin
                rdata_d = step_q;
            end else if (avs_address[7:0] == REG_STATUS) begin
                rdata_d = {bad_q, 7'h0, len_q, n_q, mtype_q, abort_q, err_q, done_q,
                           busy};
            end else begin
                rdata_d = 32'h0;
            end
        end
        if (regWr && !isMem) begin
            if (avs_address[7:0] == REG_CTRL) begin
                ctrl_d = {25'h0, avs_writedata[6:1], 1'b0};
                go_d = avs_writedata[0] && !busy;
            end else if (avs_address[7:0] == REG_FRAME) begin
                frame_d = {16'h0, avs_writedata[15:0]};
            end else if (avs_address[7:0] == REG_ADDR) begin
                addr_d = {12'h0, avs_writedata[19:0]};
            end else if (avs_address[7:0] == REG_DATA) begin
                data_d = {4'h0, avs_writedata[27:0]};
            end else if (avs_address[7:0] == REG_BASE) begin
                base_d = {8'h0, avs_writedata[23:0]};
            end else if (avs_address[7:0] == REG_STEP) begin
                step_d = {20'h0, avs_writedata[11:0]};
            end else if (avs_address[7:0] == REG_MTX && avs_writedata[3:0] < 4'hf) begin
                mtx_d[avs_writedata[3:0]] = {avs_writedata[12], avs_writedata[11:4]};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= 32'h0;
            frame_q <= 32'h0;
            addr_q <= 32'h0;
            data_q <= 32'h0;
            base_q <= 32'h0;
            step_q <= 32'h0;
            rdata_q <= 32'h0;
            wait_q <= 1'b1;
            go_q <= 1'b0;
            for (int i = 0; i < MTX_TYPES; i++) begin
                mtx_q[i] <= 9'h0;
            end
        end else begin
            ctrl_q <= ctrl_d;
            frame_q <= frame_d;
            addr_q <= addr_d;
            data_q <= data_d;
            base_q <= base_d;
            step_q <= step_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
            go_q <= go_d;
            mtx_q <= mtx_d;
        end
    end

    // matrix lookup: first valid entry holding the received address
    logic [3:0] hit;
    logic       anyMtx;
    always_comb begin
        hit = 4'h0;
        anyMtx = 1'b0;
        for (int i = MTX_TYPES - 1; i >= 0; i--) begin
            anyMtx = anyMtx | mtx_q[i][8];
            if (mtx_q[i][8] && mtx_q[i][7:0] == rxData) begin
                hit = 4'(i + 1);
            end
        end
    end

    // sequence engine
    wire logic txFree = !txValid_q || txReady;
    logic      fin, fail;
    always_comb begin
        st_d = st_q;
        n_d = n_q;
        idx_d = idx_q;
        len_d = len_q;
        chk_d = chk_q;
        rxAdr_d = rxAdr_q;
        txData_d = txData_q;
        txValid_d = txValid_q && !txReady;
        done_d = done_q;
        err_d = err_q;
        abort_d = abort_q;
        bad_d = bad_q;
        mtype_d = mtype_q;
        memWe = 1'b0;
        memWa = 8'h0;
        memWd = 8'h0;
        fin = 1'b0;
        fail = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (go_q) begin
                    n_d = 8'h0;
                    done_d = 1'b0;
                    err_d = 1'b0;
                    abort_d = 1'b0;
                    mtype_d = 4'h0;
                    bad_d = 1'b0;
                    st_d = (cmd == CMD_RECV) ? ST_RHDR : ST_THDR;
                end
            end
            ST_THDR: if (txFree) begin
                txData_d = frame_q[7:0];
                txValid_d = 1'b1;
                chk_d = 8'h0;
                st_d = ST_TADR;
            end
            ST_TADR: if (txFree) begin
                // address sent raw; wildcard and write-word fall back to constant
                txData_d = (aAttr == ATTR_READ) ? mem[aRef] : addr_q[7:0];
                txValid_d = 1'b1;
                chk_d = chkNext(chk_q, txData_d);
                st_d = ST_TLEN;
            end
            ST_TLEN: if (txFree) begin
                txData_d = split ? 8'(dCnt << 1) : dCnt;
                txValid_d = 1'b1;
                chk_d = chkNext(chk_q, txData_d);
                idx_d = 8'h0;
                st_d = (txData_d == 8'h0) ? ST_TCHK : ST_TDAT;
            end
            ST_TDAT: if (txFree) begin
                txData_d = sendByte;
                txValid_d = 1'b1;
                chk_d = chkNext(chk_q, sendByte);
                idx_d = idx_q + 8'h1;
                if (idx_q + 8'h1 == (split ? 8'(dCnt << 1) : dCnt)) begin
                    st_d = ST_TCHK;
                end
            end
            ST_TCHK: if (txFree) begin
                txData_d = chk_q;
                txValid_d = 1'b1;
                st_d = ST_TEND;
            end
            ST_TEND: if (txFree) begin
                txData_d = frame_q[15:8];
                txValid_d = 1'b1;
                st_d = (cmd == CMD_SR) ? ST_RHDR : ST_FIN;
                fin = cmd != CMD_SR;
            end
            ST_RHDR: if (rxValid && rxData == frame_q[7:0]) begin
                chk_d = 8'h0;
                bad_d = 1'b0;
                st_d = ST_RADR;
            end
            ST_RADR: if (rxValid) begin
                rxAdr_d = rxData;
                chk_d = chkNext(chk_q, rxData);
                mtype_d = hit;
                case (aAttr)
                    ATTR_CONST: bad_d = rxData != addr_q[7:0];
                    ATTR_READ:  bad_d = rxData != mem[aRef];
                    default:    bad_d = 1'b0;
                endcase
                if (anyMtx && hit == 4'h0) begin
                    bad_d = 1'b1;
                end
                st_d = ST_RLEN;
            end
            ST_RLEN: if (rxValid) begin
                len_d = rxData;
                idx_d = 8'h0;
                chk_d = chkNext(chk_q, rxData);
                st_d = (rxData == 8'h0) ? ST_RCHK : ST_RDAT;
            end
            ST_RDAT: if (rxValid) begin
                chk_d = chkNext(chk_q, rxData);
                idx_d = idx_q + 8'h1;
                if (aAttr == ATTR_WRITE || dAttr == ATTR_WRITE) begin
                    memWe = 1'b1;
                    memWa = rxAdr_q + idx_q;
                    memWd = rxData;
                end else if (dAttr != ATTR_WILD && rxData != mem[dRef + idx_q]) begin
                    bad_d = 1'b1;
                end
                if (idx_q + 8'h1 == len_q) begin
                    st_d = ST_RCHK;
                end
            end
            ST_RCHK: if (rxValid) begin
                bad_d = bad_q || rxData != chk_q;
                st_d = ST_REND;
            end
            ST_REND: if (rxValid) begin
                fin = 1'b1;
                fail = bad_q || rxData != frame_q[15:8];
                st_d = ST_FIN;
            end
            // stay busy until the end code has left, so no byte hangs past the step
            ST_FIN: if (txFree) begin
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
        // step outcome: repeat first, then the configured action
        if (fin) begin
            if (!fail && n_q + 8'h1 < rep) begin
                n_d = n_q + 8'h1;
                st_d = (cmd == CMD_RECV) ? ST_RHDR : ST_THDR;
            end else begin
                case (fail ? step_q[11:10] : step_q[9:8])
                    ACT_END: begin
                        done_d = 1'b1;
                        err_d = fail;
                    end
                    ACT_ABORT: begin
                        done_d = 1'b1;
                        err_d = fail;
                        abort_d = 1'b1;
                    end
                    default: begin
                        n_d = 8'h0; // single step: goto and next rerun it
                        st_d = (cmd == CMD_RECV) ? ST_RHDR : ST_THDR;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            n_q <= 8'h0;
            idx_q <= 8'h0;
            len_q <= 8'h0;
            chk_q <= 8'h0;
            rxAdr_q <= 8'h0;
            txData_q <= 8'h0;
            txValid_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            abort_q <= 1'b0;
            bad_q <= 1'b0;
            mtype_q <= 4'h0;
        end else begin
            st_q <= st_d;
            n_q <= n_d;
            idx_q <= idx_d;
            len_q <= len_d;
            chk_q <= chk_d;
            rxAdr_q <= rxAdr_d;
            txData_q <= txData_d;
            txValid_q <= txValid_d;
            done_q <= done_d;
            err_q <= err_d;
            abort_q <= abort_d;
            bad_q <= bad_d;
            mtype_q <= mtype_d;
        end
    end

    // data memory: engine writes win; bus writes wait while busy
    always_ff @(posedge clk_sys) begin
        if (memWe) begin
            mem[memWa] <= memWd;
        end else if (regWr && isMem) begin
            mem[wIdx] <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= st_d != ST_IDLE;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign txData = txData_q;
    assign txValid = txValid_q;
endmodule : cmf_framer

// >>> bench/cmf_serial_peer.sv
// far-side serial device: takes sent bytes with random stalls, plays queued bytes in
`timescale 1ns/1ns
module cmf_serial_peer (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    output logic            txReady,
    output logic      [7:0] rxData,
    output logic            rxValid
);
    logic [7:0] txSeen[$];
    logic [7:0] rxQ[$];
    int         seed = 32'h49d3;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            txReady <= 1'b0;
            rxValid <= 1'b0;
            rxData  <= 8'h5a;
        end else begin
            if (txValid && txReady) txSeen.push_back(txData);
            // stall about a third of the cycles so held bytes get exercised
            txReady <= ($random(seed) % 3) != 0;
            if (rxQ.size() > 0) begin
                rxValid <= 1'b1;
                rxData  <= rxQ.pop_front();
            end else begin
                // idle line toggles so a stale byte is never mistaken for data
                rxValid <= 1'b0;
                rxData  <= ~rxData;
            end
        end
    end
endmodule : cmf_serial_peer

// >>> bench/cmf_framer_monitor.sv
// port checker for the message framer
`timescale 1ns/1ns
module cmf_framer_monitor
    import cmf_pkg::*;
#(
    parameter int MEM_WORDS = 256
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [10:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [7:0]  txData,
    input wire logic        txValid,
    input wire logic        txReady,
    input wire logic [7:0]  rxData,
    input wire logic        rxValid,
    input wire logic        busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_read_prompt: assert property ($rose(avs_read) |=> !avs_waitrequest)
        else $error("read not answered one cycle after raise");
    a_no_stray_answer: assert property (!avs_waitrequest |-> (avs_read || avs_write))
        else $error("answer without request");
    a_tx_byte_holds: assert property (txValid && !txReady |=> txValid && $stable(txData))
        else $error("transmit byte dropped or changed before taken");
    a_tx_in_step: assert property (txValid |-> busy)
        else $error("byte offered outside a step");
    a_rdata_holds: assert property (avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data changed outside an answer");
    a_start_runs: assert property ((avs_write && !avs_waitrequest && !busy
        && avs_address == 11'h000 && avs_writedata[0]) |-> ##[1:3] busy)
        else $error("start write did not launch a step");
    a_reset_idle: assert property ($fell(rst) |->
        avs_waitrequest && !txValid && !busy && avs_readdata == 32'h0)
        else $error("outputs not at reset values");
    c_tx_taken: cover property (txValid && txReady);
    c_read_done: cover property (avs_read && !avs_waitrequest);
    c_step_end: cover property ($fell(busy));
endmodule : cmf_framer_monitor
bind cmf_framer cmf_framer_monitor #(.MEM_WORDS(MEM_WORDS)) mon_u (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .busy(busy));

// >>> bench/tb_top.sv
// self-checking bench for the message framer
`timescale 1ns/1ns
module tb_top
    import cmf_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [10:0] avsAddress = 11'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic [7:0]  txData, rxData;
    logic        txValid, txReady, rxValid, busy;
    int          mismatches = 0;
    int          checked = 0;
    int          seed = 32'h49d3;
    int          mem[256];
    int          expQ[$];
    logic [31:0] r;
    always #5 clk_sys = ~clk_sys;
    cmf_framer #(.MEM_WORDS(256)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .txData(txData), .txValid(txValid),
        .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .busy(busy));
    cmf_serial_peer peer_u (
        .clk_sys(clk_sys), .rst(rst), .txData(txData), .txValid(txValid),
        .txReady(txReady), .rxData(rxData), .rxValid(rxValid));
    task automatic stop_test();
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one bus cycle held until waitrequest is sampled low, then one idle edge
    task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWritedata <= d;
        avsRead <= !wr;
        avsWrite <= wr;
        // only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge clk_sys);
        end while (avsWaitrequest !== 1'b0);
        r = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic run_step(input logic [31:0] ctrl);
        int n;
        n = 0;
        bus(1'b1, 11'h000, ctrl);
        while (busy !== 1'b1 && n < 20) begin @(posedge clk_sys); n++; end
        check("busy rise", busy, 1'b1);
    endtask : run_step
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin @(posedge clk_sys); n++; end
        check("busy fall", busy, 1'b0);
    endtask : wait_idle
    function automatic int hexc(input int v);
        return (v < 10) ? 8'h30 + v : 8'h37 + v;
    endfunction : hexc
    function automatic int fold(input int chk, input int s, input int x);
        int c;
        if (chk == 0) return (s + x) & 255;
        if (chk == 1) return s ^ x;
        c = s ^ x;
        repeat (8) c = (c & 128) ? ((c << 1) ^ 7) & 255 : (c << 1) & 255;
        return c;
    endfunction : fold
    task automatic expect_frame(input int chk, input int conv, input int base);
        int b[$];
        int s;
        b.push_back(8'h11);
        b.push_back(conv == 0 ? 3 : 6);
        for (int k = 0; k < 3; k++) begin
            if (conv == 0) b.push_back(mem[base + k]);
            else if (conv == 1) b.push_back(hexc(mem[base + k] >> 4));
            else b.push_back(mem[base + k] >> 4);
            if (conv == 1) b.push_back(hexc(mem[base + k] & 15));
            else if (conv == 2) b.push_back(mem[base + k] & 15);
        end
        s = 0;
        foreach (b[i]) s = fold(chk, s, b[i]);
        expQ.push_back(8'h02);
        foreach (b[i]) expQ.push_back(b[i]);
        expQ.push_back(s);
        expQ.push_back(8'h03);
    endtask : expect_frame
    task automatic recv(input int ad, input int bad, input int mt);
        int s;
        int d0;
        int d1;
        logic [7:0] f[8];
        d0 = $random(seed) & 255;
        d1 = $random(seed) & 255;
        s = (ad + 2 + d0 + d1 + (bad & 1)) & 255;
        run_step({25'h0, CONV_NONE, CHK_SUM, CMD_RECV, 1'b1});
        // junk before the start code must be dropped; bad 1 spoils the check, 2 misses the matrix
        f = '{8'h55, 8'h02, ad[7:0], 8'h02, d0[7:0], d1[7:0], s[7:0], 8'h03};
        foreach (f[i]) peer_u.rxQ.push_back(f[i]);
        wait_idle();
        bus(1'b0, REG_STATUS, 32'h0);
        check("rx error", r[2], bad != 0);
        check("rx done", r[1], 1'b1);
        check("rx abort", r[3], bad == 2);
        check("rx type", r[7:4], mt);
        if (bad == 0) begin
            bus(1'b0, 11'h400 | (ad << 2), 32'h0);
            check("rx store 0", r[7:0], d0);
            bus(1'b0, 11'h400 | ((ad + 1) << 2), 32'h0);
            check("rx store 1", r[7:0], d1);
        end
    endtask : recv
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, 11'h020, 32'h0);
        check("unmapped", r, 32'h0);
        for (int i = 0; i < 16; i++) begin
            mem[i] = $random(seed) & 255;
            bus(1'b1, 11'h400 | (i << 2), mem[i]);
        end
        bus(1'b0, 11'h40c, 32'h0);
        check("mem word", r[7:0], mem[3]);
        bus(1'b1, REG_FRAME, 32'h0302);
        bus(1'b1, REG_ADDR, 32'h11);
        // check kind and conversion walk together; the last pass repeats with scale 1
        for (int c = 0; c < 3; c++) begin
            bus(1'b1, REG_DATA, {4'h0, c == 2 ? 8'h1 : 8'h0, 8'h4, 8'h3, REF_ABS, ATTR_READ});
            bus(1'b1, REG_STEP, c == 2 ? 32'h2 : 32'h1);
            for (int n = 0; n < (c == 2 ? 2 : 1); n++) expect_frame(c, c, 4 + n);
            run_step({25'h0, c[1:0], c[1:0], CMD_SEND, 1'b1});
            wait_idle();
            check("tx count", peer_u.txSeen.size(), expQ.size());
            while (expQ.size() > 0 && peer_u.txSeen.size() > 0)
                check("tx byte", peer_u.txSeen.pop_front(), expQ.pop_front());
            peer_u.txSeen.delete();
            expQ.delete();
        end
        bus(1'b1, REG_ADDR, {12'h0, ATTR_WILD, 8'h11});
        bus(1'b1, REG_DATA, {24'h0, REF_ABS, ATTR_WRITE});
        // single run per receive step; end on both outcomes
        bus(1'b1, REG_STEP, 32'h1);
        recv(8'h30, 0, 0);
        recv(8'h40, 1, 0);
        bus(1'b1, REG_MTX, {19'h0, 1'b1, 8'h30, 4'h0});
        recv(8'h30, 0, 1);
        // error outcome now aborts; an address outside the matrix is an error
        bus(1'b1, REG_STEP, 32'hc01);
        recv(8'h50, 2, 0);
        stop_test();
    end
endmodule : tb_top
